/* rtl/framer_test_pkg.sv */
// Constants, register map and carrier types of the framer test supervision block
// What this block does
// - Simulation keeps traffic, hides genuine alarms
// - Simulation sets all four alarms in either mode
// - PCM30 simulation follows enable bit level
// - PCM24 enable rising edge advances step counter
// - PCM24 clears only at step 0 (STEP_DONE)
// - Parity generated at speech memory inputs
// - Selected channel parity errors set flags
// - Any channel parity error sets global flag
// - Receive parity output aligned, sense selectable
// - Loop one selected channel system to system
// - PCM24 pure loop drops signaling bit
// - Looped channel sends idle code to line
// - Readback test bit exposes control registers
// - PCM30 doubleframe even parity on pin
// - Replica outputs continuously copy line outputs
// - Carrier pin or control bit sends AIS
// - PCM30 async pass needs two bits
// - Slot zero transparency bypasses own framing
// - PCM24 F-bit forwarded, bit 1 flags DL
// - PCM24 system bit 8 becomes F-bit
// - Replica polarity set by sense bit
`default_nettype none
package framer_test_pkg;
   localparam logic [7:0]  CTRL_OFS   = 8'h00;
   localparam logic [7:0]  PSEL_OFS   = 8'h04;
   localparam logic [7:0]  LOOP_OFS   = 8'h08;
   localparam logic [7:0]  IDLE_OFS   = 8'h0C;
   localparam logic [7:0]  STAT_OFS   = 8'h10;
   localparam logic [7:0]  CNT_OFS    = 8'h14;
   localparam logic [16:0] CTRL_RST   = 17'h00000;
   localparam logic [4:0]  PSEL_RST   = 5'h00;
   localparam logic [4:0]  LOOP_RST   = 5'h00;
   localparam logic [7:0]  IDLE_RST   = 8'h54;
   localparam logic [4:0]  LAST_E1    = 5'h1F;
   localparam logic [4:0]  LAST_T1    = 5'h18;
   localparam logic [2:0]  STEP_DONE  = 3'h0;
   localparam logic [7:0]  AIS_BYTE   = 8'hFF;

   // Control word, bit 16 down to bit 0
   typedef struct packed {
      logic crc_multiframe;
      logic pure_data_return;
      logic replica_sense;
      logic rx_parity_sense;
      logic ext_tx_parity_sense;
      logic ext_tx_parity_enable;
      logic t1_transparent;
      logic slot_zero_transparent;
      logic rx_transparent;
      logic ais_disable;
      logic send_ais;
      logic control_readback;
      logic clear_channel_parity;
      logic clear_indications;
      logic simulation_enable;
      logic reserved0;
      logic pcm24;
   } ctrl_t;

   typedef struct packed {
      logic nos;
      logic ais;
      logic los;
      logic rai;
   } alarms_t;

   typedef struct packed {
      logic       valid;
      logic [4:0] slot;
      logic [7:0] system_pcm_in;
      logic       sig_bit;
      logic       tx_parity_input;
      logic [7:0] line_in;
      logic       f_bit;
      logic       dl_position;
      logic [7:0] framing_word;
      logic       framer_f_bit;
   } slot_in_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] system_pcm_out;
      logic       rx_parity_output;
      logic [7:0] line_byte;
      logic [7:0] line_out_plus;
      logic [7:0] line_out_minus;
      logic [7:0] replica_out_plus;
      logic [7:0] replica_out_minus;
      logic       line_f_bit;
   } slot_out_t;

   typedef struct packed {
      logic [7:0] framing;
      logic [7:0] code_violation;
      logic [7:0] crc;
   } counters_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WR   = 2'b01,
      BUS_RD   = 2'b10,
      BUS_RDY  = 2'b11
   } bus_st_t;
endpackage
`default_nettype wire

/* rtl/framer_test_supervision.sv */
// Test supervision of a primary-rate framer: simulation, parity, loopback, replicas
`default_nettype none
module framer_test_supervision (
   input  wire logic                         CORE_CLK_I,
   input  wire logic                         RESETN_I,
   input  wire logic                         HSEL_I,
   input  wire logic [31:0]                  HADDR_I,
   input  wire logic [1:0]                   HTRANS_I,
   input  wire logic                         HWRITE_I,
   input  wire logic [2:0]                   HSIZE_I,
   input  wire logic [31:0]                  HWDATA_I,
   input  wire logic                         HREADY_I,
   output logic      [31:0]                  HRDATA_O,
   output logic                              HREADYOUT_O,
   output logic                              HRESP_O,
   input  wire framer_test_pkg::slot_in_t    SLOT_I,
   input  wire framer_test_pkg::alarms_t     ALARM_I,
   input  wire logic                         RX_SYNC_I,
   input  wire logic                         COS_I,
   output framer_test_pkg::slot_out_t        SLOT_O,
   output framer_test_pkg::alarms_t          ALARM_O,
   output logic                              RAI_SEND_O,
   output logic                              DOUBLEFRAME_PARITY_O
);

   typedef struct packed {
      framer_test_pkg::ctrl_t     ctrl;
      logic [4:0]                 psel;
      logic [4:0]                 loop_ch;
      logic [7:0]                 idle;
      framer_test_pkg::bus_st_t   bus;
      logic [7:0]                 addr;
      logic [31:0]                rdata;
      logic [31:0][8:0]           rx_mem;
      logic [31:0][8:0]           tx_mem;
      logic [2:0]                 step;
      logic                       sim_prev;
      logic                       rx_pe;
      logic                       tx_pe;
      logic                       g_pe;
      logic                       rx_slip;
      logic                       tx_slip;
      framer_test_pkg::counters_t cnt;
      logic                       frame_odd;
      logic                       df_acc;
      logic                       df_out;
      logic                       mark_pol;
      framer_test_pkg::slot_out_t out;
      framer_test_pkg::alarms_t   alarms;
      logic                       rai;
   } state_t;

   state_t q, d;

   logic        addr_phase;
   logic        sim_active;
   logic        last_slot;
   logic        loop_hit;
   logic [7:0]  rx_in;
   logic [8:0]  rx_rd;
   logic        rx_err;
   logic        tx_par_in;
   logic [8:0]  tx_rd;
   logic        tx_err;
   logic [7:0]  loop_data;
   logic [7:0]  line_byte;
   logic [7:0]  plus;
   logic [7:0]  minus;
   logic        pol;
   logic        clr_ok;
   logic [31:0] rd_mux;
   framer_test_pkg::ctrl_t ctrl_vis;

   assign addr_phase = HSEL_I && HTRANS_I[1] && HREADY_I;

   always_comb begin
      d = q;
      pol = q.mark_pol;
      plus = 8'h00;
      minus = 8'h00;
      sim_active = q.ctrl.pcm24 ? (q.step != framer_test_pkg::STEP_DONE)
                                : q.ctrl.simulation_enable;
      last_slot = (SLOT_I.slot == (q.ctrl.pcm24 ? framer_test_pkg::LAST_T1
                                                : framer_test_pkg::LAST_E1));
      loop_hit = (q.loop_ch != 5'h00) && (SLOT_I.slot == q.loop_ch);

      // Receive path into speech memory
      if (q.ctrl.pcm24 && q.ctrl.t1_transparent && SLOT_I.slot == 5'h00) begin
         rx_in = {SLOT_I.dl_position, 6'h00, SLOT_I.f_bit};
      end else if (!q.ctrl.pcm24 && !RX_SYNC_I
                   && !(q.ctrl.ais_disable && q.ctrl.rx_transparent)) begin
         rx_in = framer_test_pkg::AIS_BYTE;
      end else begin
         rx_in = SLOT_I.line_in;
      end
      rx_rd  = q.rx_mem[SLOT_I.slot];
      rx_err = ^rx_rd;

      // Transmit path; PCM30 bypasses the transmit memory
      // external parity xor sense bit, stored as bit 8
      tx_par_in = q.ctrl.ext_tx_parity_enable
                ? (SLOT_I.tx_parity_input ^ q.ctrl.ext_tx_parity_sense)
                : ^SLOT_I.system_pcm_in;
      tx_rd  = q.ctrl.pcm24 ? q.tx_mem[SLOT_I.slot] : {tx_par_in, SLOT_I.system_pcm_in};
      tx_err = ^tx_rd;

      loop_data = (q.ctrl.pcm24 && !q.ctrl.pure_data_return)
                ? {SLOT_I.system_pcm_in[7:1], SLOT_I.sig_bit} : SLOT_I.system_pcm_in;

      if (COS_I || q.ctrl.send_ais) begin
         line_byte = framer_test_pkg::AIS_BYTE;
      end else if (loop_hit) begin
         line_byte = q.idle;
      end else if (!q.ctrl.pcm24 && SLOT_I.slot == 5'h00 && !q.ctrl.slot_zero_transparent) begin
         line_byte = SLOT_I.framing_word;
      end else begin
         line_byte = tx_rd[7:0];
      end

      // Alternate mark inversion, first bit of the slot first; zero
      // substitution of the line code is left to the line coder downstream
      for (int i = 7; i >= 0; i--) begin
         if (line_byte[i]) begin
            plus[i]  = !pol;
            minus[i] = pol;
            pol      = !pol;
         end
      end

      if (SLOT_I.valid) begin
         d.rx_mem[SLOT_I.slot] = {^rx_in, rx_in};
         if (q.ctrl.pcm24) begin
            d.tx_mem[SLOT_I.slot] = {tx_par_in, SLOT_I.system_pcm_in};
         end
         d.mark_pol = pol;
         d.out.valid = 1'b1;
         d.out.system_pcm_out = loop_hit ? loop_data : rx_rd[7:0];
         d.out.rx_parity_output = rx_rd[8] ^ q.ctrl.rx_parity_sense;
         d.out.line_byte = line_byte;
         d.out.line_out_plus = plus;
         d.out.line_out_minus = minus;
         d.out.replica_out_plus = plus ^ {8{q.ctrl.replica_sense}};
         d.out.replica_out_minus = minus ^ {8{q.ctrl.replica_sense}};
         if (q.ctrl.pcm24 && SLOT_I.slot == 5'h00) begin
            d.out.line_f_bit = q.ctrl.t1_transparent ? SLOT_I.system_pcm_in[0]
                                                     : SLOT_I.framer_f_bit;
         end
         if (!q.ctrl.pcm24) begin
            d.df_acc = q.df_acc ^ (^rx_rd[7:0]);
            if (last_slot) begin
               d.frame_odd = !q.frame_odd;
               if (q.frame_odd) begin
                  d.df_out = q.df_acc ^ (^rx_rd[7:0]);
                  d.df_acc = 1'b0;
               end
            end
         end
      end else begin
         d.out.valid = 1'b0;
      end

      d.sim_prev = q.ctrl.simulation_enable;
      if (q.ctrl.pcm24 && q.ctrl.simulation_enable && !q.sim_prev) begin
         d.step = q.step + 3'h1;
      end

      clr_ok = q.ctrl.clear_indications && (!q.ctrl.pcm24 || q.step == framer_test_pkg::STEP_DONE);
      if (clr_ok) begin
         d.rx_slip = 1'b0;
         d.tx_slip = 1'b0;
         d.cnt = '0;
      end
      if (q.ctrl.clear_channel_parity || clr_ok) begin
         d.rx_pe = 1'b0;
         d.tx_pe = 1'b0;
         d.g_pe = 1'b0;
      end
      if (sim_active) begin
         d.rx_slip = 1'b1;
         d.tx_slip = 1'b1;
         d.rx_pe = 1'b1;
         d.tx_pe = 1'b1;
         d.g_pe = 1'b1;
         if (SLOT_I.valid && last_slot) begin
            d.cnt.framing = q.cnt.framing + 8'h01;
            d.cnt.code_violation = q.cnt.code_violation + 8'h01;
            if (q.ctrl.crc_multiframe) begin
               d.cnt.crc = q.cnt.crc + 8'h01;
            end
         end
      end
      if (SLOT_I.valid) begin
         if (rx_err && SLOT_I.slot == q.psel) begin
            d.rx_pe = 1'b1;
         end
         if (tx_err && SLOT_I.slot == q.psel) begin
            d.tx_pe = 1'b1;
         end
         if (rx_err || tx_err) begin
            d.g_pe = 1'b1;
         end
      end

      d.alarms = sim_active ? '1 : ALARM_I;
      d.rai = !sim_active && ALARM_I.los;

      ctrl_vis = q.ctrl;
      ctrl_vis.clear_indications = 1'b0;
      ctrl_vis.clear_channel_parity = 1'b0;
      case (HADDR_I[7:0])
         framer_test_pkg::CTRL_OFS: rd_mux = q.ctrl.control_readback ? {15'h0000, ctrl_vis} : '0;
         framer_test_pkg::PSEL_OFS: rd_mux = q.ctrl.control_readback ? {27'h0, q.psel} : '0;
         framer_test_pkg::LOOP_OFS: rd_mux = q.ctrl.control_readback ? {27'h0, q.loop_ch} : '0;
         framer_test_pkg::IDLE_OFS: rd_mux = q.ctrl.control_readback ? {24'h0, q.idle} : '0;
         framer_test_pkg::STAT_OFS: rd_mux = {22'h0, q.df_out, q.step, q.rx_slip, q.tx_slip,
                                              q.g_pe, q.tx_pe, q.rx_pe, sim_active};
         framer_test_pkg::CNT_OFS:  rd_mux = {8'h00, q.cnt};
         default:                   rd_mux = '0;
      endcase

      // Reads take one wait state so that hrdata comes from a flop
      case (q.bus)
         framer_test_pkg::BUS_WR: begin
            case (q.addr)
               framer_test_pkg::CTRL_OFS: d.ctrl = framer_test_pkg::ctrl_t'(HWDATA_I[16:0]);
               framer_test_pkg::PSEL_OFS: d.psel = HWDATA_I[4:0];
               framer_test_pkg::LOOP_OFS: d.loop_ch = HWDATA_I[4:0];
               framer_test_pkg::IDLE_OFS: d.idle = HWDATA_I[7:0];
               default: ;
            endcase
         end
         framer_test_pkg::BUS_RD: begin
            d.bus = framer_test_pkg::BUS_RDY;
         end
         default: ;
      endcase
      if (q.bus != framer_test_pkg::BUS_RD) begin
         d.bus = framer_test_pkg::BUS_IDLE;
         if (addr_phase) begin
            d.addr = HADDR_I[7:0];
            d.bus = HWRITE_I ? framer_test_pkg::BUS_WR : framer_test_pkg::BUS_RD;
            if (!HWRITE_I) begin
               d.rdata = rd_mux;
            end
         end
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         q <= '0;
         q.ctrl <= framer_test_pkg::ctrl_t'(framer_test_pkg::CTRL_RST);
         q.psel <= framer_test_pkg::PSEL_RST;
         q.loop_ch <= framer_test_pkg::LOOP_RST;
         q.idle <= framer_test_pkg::IDLE_RST;
         q.bus <= framer_test_pkg::BUS_IDLE;
      end else begin
         q <= d;
      end
   end

   assign HRDATA_O = q.rdata;
   assign HREADYOUT_O = (q.bus != framer_test_pkg::BUS_RD);
   assign HRESP_O = 1'b0;
   assign SLOT_O = q.out;
   assign ALARM_O = q.alarms;
   assign RAI_SEND_O = q.rai;
   assign DOUBLEFRAME_PARITY_O = q.df_out;

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESETN_I);

   property p_sim_hides;
      sim_active |=> !RAI_SEND_O && (ALARM_O == 4'hF);
   endproperty
   a_sim_hides: assert property (p_sim_hides) else $error("genuine alarm shown in simulation");

   property p_crc_gated;
      !q.ctrl.crc_multiframe && !q.ctrl.clear_indications |=> $stable(q.cnt.crc);
   endproperty
   a_crc_gated: assert property (p_crc_gated) else $error("CRC count moved without multiframe");

   property p_e1_release;
      !q.ctrl.pcm24 && !q.ctrl.simulation_enable ##1 !q.ctrl.pcm24 && !q.ctrl.simulation_enable
         |=> ALARM_O == $past(ALARM_I);
   endproperty
   a_e1_release: assert property (p_e1_release) else $error("PCM30 alarms stuck after simulation");

   property p_t1_step;
      q.ctrl.pcm24 && q.ctrl.simulation_enable && !q.sim_prev |=> q.step == $past(q.step) + 3'h1;
   endproperty
   a_t1_step: assert property (p_t1_step) else $error("step counter did not advance");

   property p_t1_hold;
      q.ctrl.pcm24 && q.step != 3'h0 && q.rx_slip |=> q.rx_slip;
   endproperty
   a_t1_hold: assert property (p_t1_hold) else $error("slip cleared mid simulation");

   property p_rx_pe;
      SLOT_I.valid && rx_err && SLOT_I.slot == q.psel |=> q.rx_pe ##1
         (q.rx_pe || $past(q.ctrl.clear_channel_parity || q.ctrl.clear_indications));
   endproperty
   a_rx_pe: assert property (p_rx_pe) else $error("selected receive parity error lost");

   property p_gpe;
      SLOT_I.valid && (rx_err || tx_err) |=> q.g_pe;
   endproperty
   a_gpe: assert property (p_gpe) else $error("global parity flag missed");

   property p_tx_pe;
      SLOT_I.valid && tx_err && SLOT_I.slot == q.psel |=> q.tx_pe;
   endproperty
   a_tx_pe: assert property (p_tx_pe) else $error("selected transmit parity error lost");

   property p_rai_follows;
      !sim_active |=> RAI_SEND_O == $past(ALARM_I.los);
   endproperty
   a_rai_follows: assert property (p_rai_follows) else $error("remote alarm request wrong");

   property p_hidden;
      addr_phase && !HWRITE_I && !q.ctrl.control_readback
         && HADDR_I[7:0] == framer_test_pkg::IDLE_OFS |=> HRDATA_O == 32'h0;
   endproperty
   a_hidden: assert property (p_hidden) else $error("control register read without test bit");

   property p_loop;
      SLOT_I.valid && loop_hit && !COS_I && !q.ctrl.send_ais
         |=> SLOT_O.system_pcm_out == $past(loop_data) && SLOT_O.line_byte == $past(q.idle);
   endproperty
   a_loop: assert property (p_loop) else $error("loop channel or idle code wrong");

   property p_ais;
      SLOT_I.valid && (COS_I || q.ctrl.send_ais) |=> SLOT_O.line_byte == 8'hFF;
   endproperty
   a_ais: assert property (p_ais) else $error("AIS not sent");

   property p_replica;
      SLOT_I.valid |=> SLOT_O.replica_out_plus
         == (SLOT_O.line_out_plus ^ {8{$past(q.ctrl.replica_sense)}});
   endproperty
   a_replica: assert property (p_replica) else $error("replica differs from line");

   c_t1_wrap: cover property (q.ctrl.pcm24 && q.step == 3'h7 ##[1:1000] q.step == 3'h0);
   c_loop:    cover property (SLOT_I.valid && loop_hit);
   c_rx_pe:   cover property ($rose(q.rx_pe));
   c_read:    cover property (q.bus == framer_test_pkg::BUS_RD ##1 HREADYOUT_O);

endmodule // framer_test_supervision
`default_nettype wire

/* test/framer_highway_model.sv */
// Behavioural far side: system highway and line, one slot every other cycle
`default_nettype none
module framer_highway_model (
   input  wire logic                 clk_i,
   input  wire logic                 rstn_i,
   input  wire logic                 pcm24_i,
   input  wire logic [5:0]           bad_slot_i,
   output framer_test_pkg::slot_in_t slot_o,
   output logic      [15:0]          frames_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] n_q;
   logic [4:0] last;
   assign last = pcm24_i ? framer_test_pkg::LAST_T1 : framer_test_pkg::LAST_E1;
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         slot_o <= '0;
         n_q <= 5'h00;
         frames_o <= 16'h0000;
      end else if (slot_o.valid) begin
         // Released lines show the inverse, never the last value
         slot_o <= {1'b0, ~slot_o[$bits(framer_test_pkg::slot_in_t)-2:0]};
         n_q <= (n_q >= last) ? 5'h00 : n_q + 5'h01;
         if (n_q >= last) frames_o <= frames_o + 16'h0001;
      end else begin
         slot_o.valid <= 1'b1;
         slot_o.slot <= n_q;
         slot_o.system_pcm_in <= {n_q, 3'h3};
         slot_o.sig_bit <= 1'b0;
         slot_o.tx_parity_input <= ^{n_q, 3'h3} ^ ({1'b0, n_q} == bad_slot_i);
         slot_o.line_in <= {n_q, 3'h0} + 8'h11;
         slot_o.f_bit <= 1'b1;
         slot_o.dl_position <= 1'b1;
         slot_o.framing_word <= 8'h1B;
         slot_o.framer_f_bit <= 1'b0;
      end
   end
endmodule // framer_highway_model
`default_nettype wire

/* test/framer_test_supervision_tb_top.sv */
// Self-checking bench of the framer test supervision block
`default_nettype none
module framer_test_supervision_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic sync = 1'b1;
   logic cos = 1'b0;
   logic rai;
   logic dfp;
   logic [5:0] bad = 6'h3F;
   logic m24 = 1'b0;
   logic [15:0] frm;
   logic [4:0] last_n = 5'h00;
   logic [4:0] lp = 5'h00;
   logic [31:0] r;
   int bad_count = 0;
   int checks = 0;
   framer_test_pkg::slot_in_t si;
   framer_test_pkg::slot_out_t so;
   framer_test_pkg::slot_out_t cap [0:31];
   framer_test_pkg::alarms_t alm = '0;
   framer_test_pkg::alarms_t alo;
   framer_test_pkg::ctrl_t c = '0;
   always #12.5 clk = ~clk;
   framer_test_supervision framer_test_supervision_inst (
      .CORE_CLK_I(clk), .RESETN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
      .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .SLOT_I(si), .ALARM_I(alm), .RX_SYNC_I(sync), .COS_I(cos), .SLOT_O(so),
      .ALARM_O(alo), .RAI_SEND_O(rai), .DOUBLEFRAME_PARITY_O(dfp));
   framer_highway_model framer_highway_model_inst (
      .clk_i(clk), .rstn_i(rstn), .pcm24_i(m24), .bad_slot_i(bad),
      .slot_o(si), .frames_o(frm));
   // Output pulse follows the slot taken one edge earlier
   always @(posedge clk) begin
      if (si.valid) last_n <= si.slot;
      if (so.valid) cap[last_n] <= so;
   end
   task automatic report_and_stop;
      if (bad_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic tmo;
      bad_count++;
      $display("[FAIL] %0t wait timed out", $time);
      report_and_stop();
   endtask
   task automatic hwait;
      int i;
      i = 0;
      @(posedge clk);
      while (hready !== 1'b1) begin
         @(posedge clk);
         i++;
         if (i > 40) tmo();
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      hwait();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      hwait();
      r = hrdata;
   endtask
   task automatic wc;
      xfer(1'b1, framer_test_pkg::CTRL_OFS, {15'h0, c});
   endtask
   // Read waits two edges so the previous write has landed
   task automatic rd(input logic [7:0] a);
      repeat (2) @(posedge clk);
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic frames(input int k);
      int i;
      logic [15:0] t;
      t = frm + k[15:0];
      i = 0;
      while (frm !== t) begin
         @(posedge clk);
         i++;
         if (i > 9000) tmo();
      end
   endtask
   function automatic logic [7:0] sb(input int n);
      return {n[4:0], 3'h3};
   endfunction
   function automatic logic [7:0] e_rx(input int n);
      if (lp != 5'h00 && lp == n)
         return (c.pcm24 && !c.pure_data_return) ? (sb(n) & 8'hFE) : sb(n);
      if (!c.pcm24 && !sync && !(c.ais_disable && c.rx_transparent)) return 8'hFF;
      return {n[4:0], 3'h0} + 8'h11;
   endfunction
   function automatic logic [7:0] e_tx(input int n);
      if (cos || c.send_ais) return framer_test_pkg::AIS_BYTE;
      if (lp != 5'h00 && lp == n) return framer_test_pkg::IDLE_RST;
      if (n == 0 && !c.slot_zero_transparent) return 8'h1B;
      return sb(n);
   endfunction
   task automatic scan;
      framer_test_pkg::slot_out_t o;
      logic [7:0] x;
      // Memory paths lag a frame, and the first frame after a change is mixed
      frames(3);
      for (int n = 1; n <= (c.pcm24 ? 24 : 31); n++) begin
         o = cap[n];
         x = e_rx(n);
         chk(o.system_pcm_out, x, "rx data");
         chk(o.line_byte, e_tx(n), "tx data");
         if (lp != n) chk(o.rx_parity_output, ^x ^ c.rx_parity_sense, "rx parity");
         chk({o.replica_out_plus, o.replica_out_minus}, {16{c.replica_sense}} ^
             {o.line_out_plus, o.line_out_minus}, "replica");
         chk({o.line_out_plus & o.line_out_minus, o.line_out_plus | o.line_out_minus},
             {8'h00, e_tx(n)}, "rails");
      end
      if (!c.pcm24) chk(cap[0].line_byte, e_tx(0), "slot 0 tx");
   endtask
   task automatic pclr;
      c.clear_indications = 1'b1;
      c.clear_channel_parity = 1'b1;
      wc();
      c.clear_indications = 1'b0;
      c.clear_channel_parity = 1'b0;
      wc();
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rd(framer_test_pkg::IDLE_OFS);
      chk(r, 32'h0, "hidden control");
      c.control_readback = 1'b1;
      c.clear_indications = 1'b1;
      wc();
      rd(framer_test_pkg::CTRL_OFS);
      chk(r, 32'h20, "ctrl readback");
      chk(hresp, 32'h0, "response");
      c.clear_indications = 1'b0;
      wc();
      rd(framer_test_pkg::IDLE_OFS);
      chk(r, 32'h54, "idle readback");
      rd(8'h20);
      chk(r, 32'h0, "unmapped");
      scan();
      chk(dfp, 32'h0, "doubleframe parity");
      c.rx_parity_sense = 1'b1;
      c.replica_sense = 1'b1;
      c.slot_zero_transparent = 1'b1;
      wc();
      lp = 5'h04;
      xfer(1'b1, framer_test_pkg::LOOP_OFS, 32'h4);
      scan();
      sync <= 1'b0;
      scan();
      c.ais_disable = 1'b1;
      c.rx_transparent = 1'b1;
      wc();
      scan();
      sync <= 1'b1;
      c.send_ais = 1'b1;
      wc();
      scan();
      c.send_ais = 1'b0;
      wc();
      cos <= 1'b1;
      scan();
      cos <= 1'b0;
      alm <= 4'h2;
      repeat (3) @(posedge clk);
      chk(alo, 32'h2, "genuine alarm");
      chk(rai, 32'h1, "genuine remote");
      c.simulation_enable = 1'b1;
      wc();
      scan();
      chk(alo, 32'hF, "simulated alarms");
      chk(rai, 32'h0, "remote hidden");
      rd(framer_test_pkg::STAT_OFS);
      chk(r[5:0] & 6'h31, 32'h31, "sim status");
      rd(framer_test_pkg::CNT_OFS);
      chk(r[7:0], 32'h0, "no crc count");
      chk(r[23:16] != 8'h00, 32'h1, "framing count");
      c.simulation_enable = 1'b0;
      wc();
      repeat (3) @(posedge clk);
      chk(alo, 32'h2, "sim removed");
      pclr();
      rd(framer_test_pkg::CNT_OFS);
      chk(r, 32'h0, "counters cleared");
      rd(framer_test_pkg::STAT_OFS);
      chk(r[5:0], 32'h0, "flags cleared");
      c.pcm24 = 1'b1;
      wc();
      m24 <= 1'b1;
      lp = 5'h02;
      xfer(1'b1, framer_test_pkg::LOOP_OFS, 32'h2);
      scan();
      c.pure_data_return = 1'b1;
      wc();
      scan();
      chk(cap[0].line_f_bit, 32'h0, "framer f bit");
      c.t1_transparent = 1'b1;
      wc();
      frames(3);
      chk(cap[0].system_pcm_out, 32'h81, "f bit forwarded");
      chk(cap[0].line_f_bit, 32'h1, "f bit inserted");
      c.t1_transparent = 1'b0;
      wc();
      frames(2);
      chk(cap[0].line_f_bit, 32'h0, "framer f bit back");
      c.crc_multiframe = 1'b1;
      for (int k = 1; k <= 8; k++) begin
         c.simulation_enable = 1'b1;
         wc();
         c.simulation_enable = 1'b0;
         wc();
         frames(1);
         rd(framer_test_pkg::STAT_OFS);
         chk(r[8:6], k % 8, "step count");
         chk(r[0], k != 8, "sim running");
      end
      rd(framer_test_pkg::CNT_OFS);
      chk(r[7:0] != 8'h00, 32'h1, "crc count");
      pclr();
      c.ext_tx_parity_enable = 1'b1;
      wc();
      xfer(1'b1, framer_test_pkg::PSEL_OFS, 32'h3);
      bad <= 6'h05;
      frames(3);
      rd(framer_test_pkg::STAT_OFS);
      chk(r[3:1], 32'h4, "global only");
      bad <= 6'h03;
      frames(2);
      bad <= 6'h3F;
      frames(2);
      rd(framer_test_pkg::STAT_OFS);
      chk(r[3:1], 32'h6, "selected sticky");
      pclr();
      frames(2);
      rd(framer_test_pkg::STAT_OFS);
      chk(r[3:1], 32'h0, "parity cleared");
      report_and_stop();
   end
endmodule // framer_test_supervision_tb_top
`default_nettype wire
